// ===== logic/srrc_consts.svh
// Constants of the suspend, resume and reset controller: SFR addresses,
// bit positions, reset values and timing figures.
// Assumes inclusion by bare name from the design files.
`ifndef SRRC_CONSTS_SVH
`define SRRC_CONSTS_SVH

// ==========================================================
// SFR addresses
`define SRRC_ADDR_PWR 8'h87
`define SRRC_ADDR_FLG 8'h91
`define SRRC_ADDR_CTL 8'hD8
`define SRRC_ADDR_ENA 8'hE8
`define SRRC_ADDR_PRI 8'hF8

// ==========================================================
// Field positions
`define SRRC_PWR_PD_BIT 0
`define SRRC_FLG_LSB 4
`define SRRC_CTL_SIXTH_EXTERNAL_INTERRUPT_FLG 3
`define SRRC_CTL_WAKE_FLG 4
`define SRRC_CTL_WAKE_EN 5
`define SRRC_CTL_BAUD_DBL 7
`define SRRC_ENA_SIXTH_EXTERNAL_INTERRUPT 4
`define SRRC_PRI_SIXTH_EXTERNAL_INTERRUPT 4
`define SRRC_SUSP_SRC_IDX 17
`define SRRC_USB_SRC_CNT 21

// ==========================================================
// Reset values
`define SRRC_RST_BYTE 8'h00

// ==========================================================
// Timing
`define SRRC_IDLE_TIME_US 3000
`define SRRC_CLK_MHZ 20
`define SRRC_IDLE_CYCLES (`SRRC_IDLE_TIME_US * `SRRC_CLK_MHZ)

`endif

// ===== logic/srrc_pkg.sv
// Types of the suspend, resume and reset controller.
// Assumes nothing beyond the constants header.
`default_nettype none

package srrc_pkg;

	// ==========================================================
	// SFR write request from the processor core
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} srrc_sfr_s;

	// ==========================================================
	// Power sequencer states
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_SUSP = 4'b0010,
		ST_CLKWAIT = 4'b0100,
		ST_RESUME = 4'b1000
	} srrc_state_e;

endpackage : srrc_pkg

`default_nettype wire

// ===== logic/srrc_idle_timer.sv
// Bus idle timer: pulses once when the bus has been quiet for COUNT cycles.
// Assumes activity is a synchronous level or pulse on the same clock.
`default_nettype none

module srrc_idle_timer #(
	parameter int COUNT = 60000
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic i_enable,
	input wire logic i_activity,
	output logic o_expired
);

	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic fired_reg;
	logic fired_next;
	logic exp_reg;
	logic exp_next;

	always_comb begin
		cnt_next = cnt_reg;
		fired_next = fired_reg;
		exp_next = 1'b0;
		if (!i_enable || i_activity) begin
			cnt_next = 32'h0000_0000; // R18
			fired_next = 1'b0;
		end else if (!fired_reg) begin
			if (cnt_reg == 32'(COUNT - 1)) begin
				exp_next = 1'b1; // R1
				fired_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cnt_reg <= 32'h0000_0000;
			fired_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			fired_reg <= fired_next;
			exp_reg <= exp_next;
		end
	end

	assign o_expired = exp_reg;

endmodule : srrc_idle_timer

`default_nettype wire

// ===== logic/srrc_top.sv
// Suspend, resume and reset controller between the USB core and the
// embedded processor: SFRs, idle detect, oscillator stop and wake.
// Assumes SFR writes and all inputs are synchronous to I_CLK.
`include "srrc_consts.svh"
`default_nettype none

// Function
// R1: Bus quiet for 3 ms is suspend; raise the USB core interrupt.
// R2: Setting the power-down bit halts the processor until an interrupt.
// R3: Power-down bit stops the oscillator and PLL.
// R4: Wake on bus activity or low wake pin; pin starts remote wakeup.
// R5: On wake restart oscillator and PLL, wait for stable clocks.
// R6: With clocks stable raise the high-priority resume interrupt.
// R7: After the resume handler the processor continues after the power-down write.
// R8: Power-down control sits at bit 0 of SFR 0x87.
// R9: Wake flag bit 4, wake enable bit 5 of SFR 0xD8.
// R10: Interrupts two to five: flags 0x91, enables 0xE8, priorities 0xF8 bits 0-3.
// R11: Sixth interrupt flag 0xD8 bit 3, enable 0xE8 bit 4, priority 0xF8 bit 4.
// R12: Processor reset follows a host-writable core bit, not the chip reset.
// R13: Without nonvolatile memory, processor stays in reset after power-up.
// R14: Host loads code first, then clears the hold bit.
// R15: With nonvolatile memory the processor leaves reset by itself.
// R16: Remote-wake interrupt source is the active-low wakeup pin.
// R17: Suspend is one of 21 sources on the USB core interrupt.
// R18: Idle timer restarts on any bus activity.
// R19: Power-down bit reads cleared once resume returns control.
module srrc_top #(
	parameter int IDLE_CYCLES = `SRRC_IDLE_CYCLES
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire srrc_pkg::srrc_sfr_s I_SFR,
	input wire logic [7:0] I_SFR_RADDR,
	output logic [7:0] O_SFR_RDATA,
	input wire logic I_USB_ACTIVITY,
	input wire logic [`SRRC_USB_SRC_CNT-1:0] I_USB_SRC,
	input wire logic I_I2C_IRQ,
	input wire logic I_INT4,
	input wire logic I_INT5_N,
	input wire logic I_SIXTH_EXTERNAL_INTERRUPT,
	input wire logic I_WAKEUP_N,
	input wire logic I_CLK_STABLE,
	input wire logic I_RESUME_DONE,
	input wire logic I_HOST_HOLD_WE,
	input wire logic I_HOST_HOLD_BIT,
	input wire logic I_EXT_NVM,
	output logic [4:0] O_IRQ_REQ,
	output logic [4:0] O_IRQ_PRIO,
	output logic O_WAKE_IRQ,
	output logic O_RESUME_IRQ,
	output logic O_CPU_HALT,
	output logic O_OSC_STOP,
	output logic O_REMOTE_WAKEUP,
	output logic O_CPU_RESET
);

	// ==========================================================
	// State
	srrc_pkg::srrc_state_e st_reg;
	srrc_pkg::srrc_state_e st_next;
	logic pd_reg;
	logic pd_next;
	logic [3:0] flg_reg;
	logic [3:0] flg_next;
	logic sixth_external_interrupt_flg_reg;
	logic sixth_external_interrupt_flg_next;
	logic wake_flg_reg;
	logic wake_flg_next;
	logic wake_en_reg;
	logic wake_en_next;
	logic baud_reg;
	logic baud_next;
	logic [7:0] ena_reg;
	logic [7:0] ena_next;
	logic [7:0] pri_reg;
	logic [7:0] pri_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rwake_reg;
	logic rwake_next;
	logic hold_reg;
	logic hold_next;
	logic strap_done_reg;
	logic strap_done_next;
	logic [3:0] prev_reg;
	logic [3:0] prev_next;

	logic suspend_evt;
	logic [`SRRC_USB_SRC_CNT-1:0] usb_src;
	logic [3:0] src_lvl;
	logic [3:0] src_rise;
	logic wr_pwr;
	logic wr_flg;
	logic wr_ctl;
	logic wake_evt;

	// ==========================================================
	// Idle detection
	srrc_idle_timer #(
		.COUNT(IDLE_CYCLES)
	) u_idle (
		.I_CLK(I_CLK),
		.I_RST(I_RST),
		.i_enable(st_reg == srrc_pkg::ST_RUN),
		.i_activity(I_USB_ACTIVITY), // R18
		.o_expired(suspend_evt) // R1
	);

	// ==========================================================
	// Event decode
	always_comb begin
		usb_src = I_USB_SRC;
		usb_src[`SRRC_SUSP_SRC_IDX] = suspend_evt; // R17
	end

	assign src_lvl = {I_SIXTH_EXTERNAL_INTERRUPT, !I_INT5_N, I_INT4, I_I2C_IRQ};
	assign src_rise = src_lvl & ~prev_reg;
	assign wr_pwr = I_SFR.wr && (I_SFR.addr == `SRRC_ADDR_PWR);
	assign wr_flg = I_SFR.wr && (I_SFR.addr == `SRRC_ADDR_FLG);
	assign wr_ctl = I_SFR.wr && (I_SFR.addr == `SRRC_ADDR_CTL);
	assign wake_evt = I_USB_ACTIVITY || !I_WAKEUP_N; // R4 R16

	// ==========================================================
	// Registers and sequencing
	always_comb begin
		st_next = st_reg;
		pd_next = pd_reg;
		flg_next = flg_reg;
		sixth_external_interrupt_flg_next = sixth_external_interrupt_flg_reg;
		wake_flg_next = wake_flg_reg;
		wake_en_next = wake_en_reg;
		baud_next = baud_reg;
		ena_next = ena_reg;
		pri_next = pri_reg;
		rwake_next = 1'b0;
		hold_next = hold_reg;
		strap_done_next = 1'b1;
		prev_next = src_lvl;

		// Software writes first, hardware sets below win
		if (wr_pwr && I_SFR.wdata[`SRRC_PWR_PD_BIT]) begin
			pd_next = 1'b1; // R8
		end
		if (wr_flg) begin
			flg_next = I_SFR.wdata[`SRRC_FLG_LSB +: 4]; // R10
		end
		if (wr_ctl) begin
			sixth_external_interrupt_flg_next = I_SFR.wdata[`SRRC_CTL_SIXTH_EXTERNAL_INTERRUPT_FLG]; // R11
			wake_flg_next = I_SFR.wdata[`SRRC_CTL_WAKE_FLG]; // R9
			wake_en_next = I_SFR.wdata[`SRRC_CTL_WAKE_EN]; // R9
			baud_next = I_SFR.wdata[`SRRC_CTL_BAUD_DBL];
		end
		if (I_SFR.wr && (I_SFR.addr == `SRRC_ADDR_ENA)) begin
			ena_next = I_SFR.wdata; // R10 R11
		end
		if (I_SFR.wr && (I_SFR.addr == `SRRC_ADDR_PRI)) begin
			pri_next = I_SFR.wdata; // R10 R11
		end

		if (|usb_src) begin
			flg_next[0] = 1'b1; // R1 R17
		end
		flg_next[3:1] = flg_next[3:1] | src_rise[2:0];
		if (src_rise[3]) begin
			sixth_external_interrupt_flg_next = 1'b1; // R11
		end
		if (!I_WAKEUP_N) begin
			wake_flg_next = 1'b1; // R16
		end

		case (st_reg)
			srrc_pkg::ST_RUN: begin
				if (pd_reg) begin
					st_next = srrc_pkg::ST_SUSP; // R2 R3
				end
			end
			srrc_pkg::ST_SUSP: begin
				if (wake_evt) begin
					st_next = srrc_pkg::ST_CLKWAIT; // R4 R5
					rwake_next = !I_WAKEUP_N; // R4
				end
			end
			srrc_pkg::ST_CLKWAIT: begin
				if (I_CLK_STABLE) begin
					st_next = srrc_pkg::ST_RESUME; // R5 R6
				end
			end
			srrc_pkg::ST_RESUME: begin
				if (I_RESUME_DONE) begin
					st_next = srrc_pkg::ST_RUN; // R7
					pd_next = 1'b0; // R19
				end
			end
			default: begin
				st_next = srrc_pkg::ST_RUN;
			end
		endcase

		// Strap is caught on the first clock after reset release
		if (!strap_done_reg && I_EXT_NVM) begin
			hold_next = 1'b0; // R15
		end else if (I_HOST_HOLD_WE) begin
			hold_next = I_HOST_HOLD_BIT; // R12 R14
		end
	end

	// ==========================================================
	// Read data
	always_comb begin
		rdata_next = `SRRC_RST_BYTE;
		case (I_SFR_RADDR)
			`SRRC_ADDR_PWR: rdata_next[`SRRC_PWR_PD_BIT] = pd_reg;
			`SRRC_ADDR_FLG: rdata_next[`SRRC_FLG_LSB +: 4] = flg_reg;
			`SRRC_ADDR_CTL: begin
				rdata_next[`SRRC_CTL_SIXTH_EXTERNAL_INTERRUPT_FLG] = sixth_external_interrupt_flg_reg;
				rdata_next[`SRRC_CTL_WAKE_FLG] = wake_flg_reg;
				rdata_next[`SRRC_CTL_WAKE_EN] = wake_en_reg;
				rdata_next[`SRRC_CTL_BAUD_DBL] = baud_reg;
			end
			`SRRC_ADDR_ENA: rdata_next = ena_reg;
			`SRRC_ADDR_PRI: rdata_next = pri_reg;
			default: rdata_next = `SRRC_RST_BYTE;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st_reg <= srrc_pkg::ST_RUN;
			pd_reg <= 1'b0;
			flg_reg <= 4'h0;
			sixth_external_interrupt_flg_reg <= 1'b0;
			wake_flg_reg <= 1'b0;
			wake_en_reg <= 1'b0;
			baud_reg <= 1'b0;
			ena_reg <= `SRRC_RST_BYTE;
			pri_reg <= `SRRC_RST_BYTE;
			rdata_reg <= `SRRC_RST_BYTE;
			rwake_reg <= 1'b0;
			hold_reg <= 1'b1; // R13
			strap_done_reg <= 1'b0;
			prev_reg <= 4'h0;
		end else begin
			st_reg <= st_next;
			pd_reg <= pd_next;
			flg_reg <= flg_next;
			sixth_external_interrupt_flg_reg <= sixth_external_interrupt_flg_next;
			wake_flg_reg <= wake_flg_next;
			wake_en_reg <= wake_en_next;
			baud_reg <= baud_next;
			ena_reg <= ena_next;
			pri_reg <= pri_next;
			rdata_reg <= rdata_next;
			rwake_reg <= rwake_next;
			hold_reg <= hold_next;
			strap_done_reg <= strap_done_next;
			prev_reg <= prev_next;
		end
	end

	// ==========================================================
	// Outputs
	assign O_SFR_RDATA = rdata_reg;
	assign O_IRQ_REQ = {sixth_external_interrupt_flg_reg & ena_reg[`SRRC_ENA_SIXTH_EXTERNAL_INTERRUPT], flg_reg & ena_reg[3:0]};
	assign O_IRQ_PRIO = pri_reg[`SRRC_PRI_SIXTH_EXTERNAL_INTERRUPT:0];
	assign O_WAKE_IRQ = wake_flg_reg & wake_en_reg;
	assign O_RESUME_IRQ = (st_reg == srrc_pkg::ST_RESUME); // R6
	assign O_CPU_HALT = (st_reg != srrc_pkg::ST_RUN); // R2
	assign O_OSC_STOP = (st_reg == srrc_pkg::ST_SUSP); // R3
	assign O_REMOTE_WAKEUP = rwake_reg;
	assign O_CPU_RESET = hold_reg; // R12

endmodule : srrc_top

`default_nettype wire

// ===== tb/srrc_top_chk_sva.sv
// Checker of the power sequence and processor reset hold at the top ports.
// Assumes it is bound onto srrc_top and that all ports share I_CLK.
`default_nettype none

module srrc_top_chk (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire srrc_pkg::srrc_sfr_s I_SFR,
	input wire logic I_USB_ACTIVITY,
	input wire logic I_WAKEUP_N,
	input wire logic I_CLK_STABLE,
	input wire logic I_RESUME_DONE,
	input wire logic I_HOST_HOLD_WE,
	input wire logic I_HOST_HOLD_BIT,
	input wire logic O_RESUME_IRQ,
	input wire logic O_CPU_HALT,
	input wire logic O_OSC_STOP,
	input wire logic O_REMOTE_WAKEUP,
	input wire logic O_CPU_RESET
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// Halted, oscillator running, resume not yet raised
	wire logic wait_st = O_CPU_HALT && !O_OSC_STOP && !O_RESUME_IRQ;

	// ==========================================================
	// Power sequence
	property p_halt; O_OSC_STOP |-> O_CPU_HALT; endproperty
	a_halt: assert property (p_halt) else $error("stop without halt");
	property p_pd;
		I_SFR.wr && I_SFR.addr == 8'h87 && I_SFR.wdata[0] && !O_CPU_HALT |-> ##2 O_OSC_STOP;
	endproperty
	a_pd: assert property (p_pd) else $error("no stop after power down");
	property p_pin; O_OSC_STOP && !I_WAKEUP_N |=> !O_OSC_STOP && O_REMOTE_WAKEUP; endproperty
	a_pin: assert property (p_pin) else $error("pin wake failed");
	property p_act;
		O_OSC_STOP && I_WAKEUP_N && I_USB_ACTIVITY |=> !O_OSC_STOP && !O_REMOTE_WAKEUP;
	endproperty
	a_act: assert property (p_act) else $error("bus wake failed");
	property p_wait; wait_st && !I_CLK_STABLE |=> !O_RESUME_IRQ && O_CPU_HALT; endproperty
	a_wait: assert property (p_wait) else $error("resume before stable");
	property p_irq; wait_st && I_CLK_STABLE |=> O_RESUME_IRQ; endproperty
	a_irq: assert property (p_irq) else $error("resume irq missing");
	property p_hold; O_RESUME_IRQ && !I_RESUME_DONE |=> O_RESUME_IRQ && O_CPU_HALT; endproperty
	a_hold: assert property (p_hold) else $error("resume irq dropped");
	property p_done; O_RESUME_IRQ && I_RESUME_DONE |=> !O_CPU_HALT && !O_RESUME_IRQ; endproperty
	a_done: assert property (p_done) else $error("no return to run");

	// ==========================================================
	// Processor reset hold
	property p_rst;
		I_HOST_HOLD_WE && !$past(I_RST) |=> O_CPU_RESET == $past(I_HOST_HOLD_BIT);
	endproperty
	a_rst: assert property (p_rst) else $error("hold bit ignored");

	c_susp: cover property (O_OSC_STOP);
	c_pin: cover property (O_REMOTE_WAKEUP);
	c_res: cover property (O_RESUME_IRQ && I_RESUME_DONE);
endmodule : srrc_top_chk

bind srrc_top srrc_top_chk u_chk (.I_CLK, .I_RST, .I_SFR, .I_USB_ACTIVITY, .I_WAKEUP_N,
	.I_CLK_STABLE, .I_RESUME_DONE, .I_HOST_HOLD_WE, .I_HOST_HOLD_BIT, .O_RESUME_IRQ,
	.O_CPU_HALT, .O_OSC_STOP, .O_REMOTE_WAKEUP, .O_CPU_RESET);

`default_nettype wire

// ===== tb/srrc_core_model.sv
// Oscillator and processor stand-in: clock settle delay and resume handler.
// Assumes one clock; i_slow picks the long settle time.
`default_nettype none

module srrc_core_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_osc_stop,
	input wire logic i_resume_irq,
	input wire logic i_slow,
	output logic o_clk_stable,
	output logic o_resume_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst || i_osc_stop) begin
			cnt_reg <= 4'h0;
		end else if (cnt_reg != 4'hF) begin
			cnt_reg <= cnt_reg + 4'h1;
		end
		o_resume_done <= i_resume_irq && !o_resume_done && !i_rst;
	end
	// Clocks settle some cycles after the oscillator restarts
	assign o_clk_stable = cnt_reg > (i_slow ? 4'h9 : 4'h2);
endmodule : srrc_core_model

`default_nettype wire

// ===== tb/test_suspend_resume_reset_control.sv
// Self-checking bench of the suspend, resume and reset controller.
// Assumes srrc_top, its checker and the core model are compiled before.
`default_nettype none

module test_suspend_resume_reset_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int IDLE = 20;
	logic clk, rst, act, wake_n, we, hbit, nvm, slow, stable, done;
	logic wirq, rirq, halt, stop, rwake, cpurst;
	logic [4:0] irq, req, prio;
	logic [20:0] usb_src;
	logic [7:0] raddr, rdata, d, en;
	logic [15:0] f;
	logic [7:0] adr [5] = '{8'h87, 8'h91, 8'hD8, 8'hE8, 8'hF8};
	srrc_pkg::srrc_sfr_s sfr;
	int seed = 32'haed9;
	int fails = 0;
	int num_checks = 0;
	int n;

	srrc_top #(.IDLE_CYCLES(IDLE)) dut (.I_CLK(clk), .I_RST(rst), .I_SFR(sfr),
		.I_SFR_RADDR(raddr), .O_SFR_RDATA(rdata), .I_USB_ACTIVITY(act), .I_USB_SRC(usb_src),
		.I_I2C_IRQ(irq[1]), .I_INT4(irq[2]), .I_INT5_N(~irq[3]), .I_SIXTH_EXTERNAL_INTERRUPT(irq[4]),
		.I_WAKEUP_N(wake_n), .I_CLK_STABLE(stable), .I_RESUME_DONE(done),
		.I_HOST_HOLD_WE(we), .I_HOST_HOLD_BIT(hbit), .I_EXT_NVM(nvm), .O_IRQ_REQ(req),
		.O_IRQ_PRIO(prio), .O_WAKE_IRQ(wirq), .O_RESUME_IRQ(rirq), .O_CPU_HALT(halt),
		.O_OSC_STOP(stop), .O_REMOTE_WAKEUP(rwake), .O_CPU_RESET(cpurst));
	srrc_core_model u_core (.i_clk(clk), .i_rst(rst), .i_osc_stop(stop),
		.i_resume_irq(rirq), .i_slow(slow), .o_clk_stable(stable), .o_resume_done(done));

	// ==========================================================
	// Helpers
	function automatic logic [15:0] flag_of(input int i);
		return (i == 4) ? 16'hD808 : {8'h91, 8'(8'h10 << i)};
	endfunction : flag_of
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		sfr <= '{1'b1, a, v};
		cyc(1);
		sfr.wr <= 1'b0;
		cyc(1);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		raddr <= a;
		cyc(2);
		chk(rdata & m, e & m);
	endtask : rdc
	task automatic conclude();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		cyc(5000);
		fails++;
		conclude();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		act = 1'b1;
		wake_n = 1'b1;
		we = 1'b0;
		hbit = 1'b0;
		nvm = 1'b0;
		slow = 1'b0;
		irq = 5'h0;
		usb_src = 21'h0;
		raddr = 8'h00;
		sfr = '0;
		cyc(20);
		rst <= 1'b0;
		cyc(3);
		chk({7'h0, cpurst}, 8'h01);
		for (int i = 0; i < 5; i++) rdc(adr[i], 8'hFF, 8'h00);
		we <= 1'b1;
		cyc(1);
		we <= 1'b0;
		cyc(1);
		chk({7'h0, cpurst}, 8'h00);
		repeat (4) begin
			d = 8'($random(seed));
			wr(8'hF8, d);
			chk({3'h0, prio}, {3'h0, d[4:0]});
			rdc(8'hF8, 8'hFF, d);
			wr(8'hE8, d);
			rdc(8'hE8, 8'h1F, d);
			wr(8'hD8, d & 8'hA0);
			rdc(8'hD8, 8'hA0, d);
			wr(8'h92, d);
			rdc(8'h92, 8'hFF, 8'h00);
		end
		for (int k = 0; k < 2; k++) begin
			en = (k == 0) ? 8'h1F : 8'h00;
			wr(8'hE8, en);
			for (int i = 0; i < 5; i++) begin
				f = flag_of(i);
				if (i == 0) begin
					usb_src <= 21'h2_0000;
					cyc(3);
					usb_src <= 21'h0;
					rdc(8'h91, 8'h10, 8'h00);
					usb_src <= 21'($random(seed)) & 21'h1D_FFFF | 21'h1;
				end else begin
					irq[i] <= 1'b1;
				end
				cyc(2);
				usb_src <= 21'h0;
				irq <= 5'h0;
				rdc(f[15:8], f[7:0], f[7:0]);
				chk({3'h0, req}, {3'h0, en[4:0] & 5'(1 << i)});
				wr(f[15:8], 8'h00);
			end
		end
		act <= 1'b0;
		cyc(10);
		act <= 1'b1;
		cyc(1);
		act <= 1'b0;
		cyc(IDLE - 6);
		rdc(8'h91, 8'h10, 8'h00);
		cyc(8);
		rdc(8'h91, 8'h10, 8'h10);
		act <= 1'b1;
		wr(8'h91, 8'h00);
		for (int w = 0; w < 2; w++) begin
			wr(8'hD8, 8'h20);
			act <= 1'b0;
			slow <= (w == 0);
			wr(8'h87, 8'h01);
			cyc(2);
			chk({6'h0, halt, stop}, 8'h03);
			if (w == 0) wake_n <= 1'b0;
			else act <= 1'b1;
			cyc(2);
			chk({5'h0, stop, rwake, wirq}, {6'h0, w == 0, w == 0});
			wake_n <= 1'b1;
			for (n = 0; n < 40 && rirq !== 1'b1; n++) cyc(1);
			chk({6'h0, halt, rirq}, 8'h03);
			for (n = 0; n < 40 && halt !== 1'b0; n++) cyc(1);
			chk({7'h0, halt}, 8'h00);
			rdc(8'h87, 8'h01, 8'h00);
			rdc(8'hD8, 8'h10, (w == 0) ? 8'h10 : 8'h00);
			wr(8'hD8, 8'h00);
		end
		nvm <= 1'b1;
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(3);
		chk({7'h0, cpurst}, 8'h00);
		conclude();
	end
endmodule : test_suspend_resume_reset_control

`default_nettype wire
